// file: core/gp_pin_mux_consts.vh
// Constants for the general-purpose pin function multiplexer
`ifndef GP_PIN_MUX_CONSTS_VH
`define GP_PIN_MUX_CONSTS_VH

// ****************************************
// Designation codes
// ****************************************
`define DES_GPIO           3'h0
`define DES_PRIMARY        3'h1
`define DES_ALT_A          3'h2
`define DES_ALT_B          3'h3
`define DES_ALT_C          3'h4

// ****************************************
// Per-pin setting byte fields
// ****************************************
`define SET_DES_LSB        0
`define SET_DES_MSB        2
`define SET_DIR_BIT        3
`define SET_OUTVAL_BIT     4
`define SET_RESET_VALUE    8'h11

// ****************************************
// Chip setting word zero fields
// ****************************************
`define CHIP_DAC_REF_LSB   0
`define CHIP_ADC_REF_LSB   2
`define CHIP_SUSPEND_INDICATOR_POL_BIT 4
`define CHIP_CFG_POL_BIT   5
`define CHIP_LED_POL_BIT   6
`define CHIP_RESET_VALUE   8'h00

// ****************************************
// Timing
// ****************************************
`define CLK_MHZ            100
`define LED_PULSE_US       5000
`define LED_PULSE_CYCLES   (`LED_PULSE_US * `CLK_MHZ)
`define RST_FILTER_NS      100
`define RST_FILTER_CYCLES  (`RST_FILTER_NS / 10)

// ****************************************
// Edge detector modes
// ****************************************
`define EDGE_NONE          2'h0
`define EDGE_RISE          2'h1
`define EDGE_FALL          2'h2
`define EDGE_BOTH          2'h3

`endif

// file: core/traffic_pulse.v
// Retriggerable traffic pulse stretcher for one activity LED
`default_nettype none
module traffic_pulse #(
  parameter integer PULSE_CYCLES = 500000,
  parameter integer CW           = 20
) (
  // Clock and reset
  input  wire          ref_clk_in,
  input  wire          rst_b_in,
  // Event and state
  input  wire          event_in,
  output wire          active_out
);

  reg [CW-1:0] count;

  // A new event restarts the pulse so steady traffic keeps the lamp lit
  always @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      count <= {CW{1'b0}};
    end else if (event_in) begin
      count <= PULSE_CYCLES[CW-1:0]; // RL21
    end else if (count != {CW{1'b0}}) begin
      count <= count - {{(CW-1){1'b0}}, 1'b1};
    end
  end

  assign active_out = (count != {CW{1'b0}});

endmodule
`default_nettype wire

// file: core/gp_pin_function_mux.v
// Function multiplexer for four general-purpose pins
// Function
// RL1 - Codes 000 GPIO, 001 dedicated function
// RL2 - Codes 010, 011, 100 select alternates
// RL3 - GPIO drives host value, returns sampled level
// RL4 - Suspend pin asserts in suspend, polarity configurable
// RL5 - Configured pin low until enumeration completes
// RL6 - Configured pin drops during suspend
// RL7 - Receive LED pulses on UART receive
// RL8 - Transmit LED pulses on UART transmit
// RL9 - Two-wire LED pulses on bus traffic
// RL10 - Pin1 drives divided clock, settable duty
// RL11 - Pin1 edge detector flags chosen edges
// RL12 - Pins1-3 route to converter channels
// RL13 - Pins2 and 3 share one DAC
// RL14 - Separate four-way references for ADC, DAC
// RL15 - Reset pin low resets, glitches filtered; code resets at once on any low pulse and filters only the release
// RL16 - Power-on pulse initializes the device
// RL17 - Load stored settings into working copy
// RL18 - Host reads/writes stored and working settings
// RL19 - Output value byte bit sets GPIO level
// RL20 - Unlisted code leaves pin high impedance
// RL21 - Retriggerable LED pulse from cycle count
`default_nettype none
`include "gp_pin_mux_consts.vh"
module gp_pin_function_mux #(
  parameter integer LED_PULSE_CYCLES = `LED_PULSE_CYCLES,
  parameter integer RST_FILTER       = `RST_FILTER_CYCLES,
  parameter integer CLKDIV_W         = 8
) (
  // Clock and resets
  input  wire          ref_clk_in,
  input  wire          rst_b_in,
  input  wire          por_pulse_in,
  // Nonvolatile store image
  input  wire [39:0]   nv_settings_in,
  // Host settings port
  input  wire          set_wr_in,
  input  wire          set_nv_in,
  input  wire [2:0]    set_addr_in,
  input  wire [7:0]    set_data_in,
  output reg  [7:0]    set_rdata_out,
  output reg  [39:0]   nv_settings_out,
  output reg           settings_ready_out,
  // Host GPIO control
  input  wire [3:0]    gpio_set_val_in,
  input  wire [3:0]    gpio_set_wr_in,
  output reg  [3:0]    gpio_level_out,
  // Clock output settings
  input  wire [CLKDIV_W-1:0] clk_div_in,
  input  wire [CLKDIV_W-1:0] clk_high_in,
  // Edge detector
  input  wire [1:0]    edge_mode_in,
  input  wire          edge_clear_in,
  output reg           edge_flag_out,
  // USB state and traffic events
  input  wire          usb_suspend_in,
  input  wire          usb_configured_in,
  input  wire          uart_rx_event_in,
  input  wire          uart_tx_event_in,
  input  wire          twowire_event_in,
  // Analog routing
  output reg  [2:0]    adc_channel_en_out,
  output reg  [1:0]    adc_reference_selector_out,
  output reg  [1:0]    dac_pin_en_out,
  output reg  [1:0]    dac_reference_selector_out,
  // Pins
  input  wire [3:0]    pin_in,
  output reg  [3:0]    pin_out,
  output reg  [3:0]    pin_oe_out
);

  // ****************************************
  // Reset filter and combined reset
  // ****************************************
  reg        rst_s1;
  reg        rst_s2;
  reg [7:0]  rst_cnt;
  reg        filt_rst_b;
  wire       core_rst_b = filt_rst_b & ~por_pulse_in; // RL16

  // Asynchronous assert, release only after a steady high run
  always @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_s1     <= 1'b0;
      rst_s2     <= 1'b0;
      rst_cnt    <= 8'h00;
      filt_rst_b <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
      if (rst_s2 && rst_cnt != RST_FILTER[7:0]) begin
        rst_cnt <= rst_cnt + 8'h01;
      end
      filt_rst_b <= rst_s2 && (rst_cnt == RST_FILTER[7:0]); // RL15
    end
  end

  // ****************************************
  // Settings: working copy and stored copy
  // ****************************************
  reg [7:0] work [0:4];
  reg       loaded;
  integer   i;

  always @(posedge ref_clk_in or negedge core_rst_b) begin
    if (!core_rst_b) begin
      for (i = 0; i < 4; i = i + 1) begin
        work[i] <= `SET_RESET_VALUE;
      end
      work[4]            <= `CHIP_RESET_VALUE;
      loaded             <= 1'b0;
      nv_settings_out    <= {5{8'h00}};
      settings_ready_out <= 1'b0;
    end else begin
      if (!loaded) begin
        for (i = 0; i < 5; i = i + 1) begin
          work[i] <= nv_settings_in[i*8 +: 8]; // RL17
        end
        nv_settings_out    <= nv_settings_in;
        loaded             <= 1'b1;
        settings_ready_out <= 1'b1;
      end else if (set_wr_in && set_addr_in < 3'h5) begin
        if (set_nv_in) begin
          nv_settings_out[set_addr_in*8 +: 8] <= set_data_in; // RL18
        end else begin
          work[set_addr_in] <= set_data_in; // RL18
        end
      end
    end
  end

  always @(posedge ref_clk_in or negedge core_rst_b) begin
    if (!core_rst_b) begin
      set_rdata_out <= 8'h00;
    end else if (set_addr_in >= 3'h5) begin
      set_rdata_out <= 8'h00;
    end else if (set_nv_in) begin
      set_rdata_out <= nv_settings_out[set_addr_in*8 +: 8]; // RL18
    end else begin
      set_rdata_out <= work[set_addr_in];
    end
  end

  wire [7:0] chip = work[4];
  wire       suspend_indicator_pol = chip[`CHIP_SUSPEND_INDICATOR_POL_BIT];
  wire       cfg_pol   = chip[`CHIP_CFG_POL_BIT];
  wire       led_pol   = chip[`CHIP_LED_POL_BIT];

  // ****************************************
  // Pin input synchronisers
  // ****************************************
  reg [3:0] pin_s1;
  reg [3:0] pin_s2;
  reg [3:0] gp_val;

  always @(posedge ref_clk_in or negedge core_rst_b) begin
    if (!core_rst_b) begin
      pin_s1         <= 4'h0;
      pin_s2         <= 4'h0;
      gpio_level_out <= 4'h0;
    end else begin
      pin_s1         <= pin_in;
      pin_s2         <= pin_s1;
      gpio_level_out <= pin_s2; // RL3
    end
  end

  // Stored default wins over host writes until loaded; host writes apply once loaded
  generate
    genvar g;
    for (g = 0; g < 4; g = g + 1) begin : gp_value
      always @(posedge ref_clk_in or negedge core_rst_b) begin
        if (!core_rst_b) begin
          gp_val[g] <= 1'b1;
        end else if (!loaded) begin
          gp_val[g] <= nv_settings_in[g*8 + `SET_OUTVAL_BIT]; // RL19
        end else if (gpio_set_wr_in[g]) begin
          gp_val[g] <= gpio_set_val_in[g]; // RL3
        end
      end
    end
  endgenerate

  // ****************************************
  // Edge detector on pin1
  // ****************************************
  wire rise = pin_s2[1] & ~gpio_level_out[1];
  wire fall = ~pin_s2[1] & gpio_level_out[1];
  wire edge_hit = (work[1][2:0] == `DES_ALT_C) &&
                  ((rise && edge_mode_in[0]) || (fall && edge_mode_in[1])); // RL11

  // A detected edge wins over a clear in the same cycle
  always @(posedge ref_clk_in or negedge core_rst_b) begin
    if (!core_rst_b) begin
      edge_flag_out <= 1'b0;
    end else if (edge_hit) begin
      edge_flag_out <= 1'b1;
    end else if (edge_clear_in) begin
      edge_flag_out <= 1'b0;
    end
  end

  // ****************************************
  // Clock output divider
  // ****************************************
  reg [CLKDIV_W-1:0] div_cnt;
  reg                clk_div;

  // Period is clk_div_in+1 cycles, high for clk_high_in cycles
  always @(posedge ref_clk_in or negedge core_rst_b) begin
    if (!core_rst_b) begin
      div_cnt <= {CLKDIV_W{1'b0}};
      clk_div <= 1'b0;
    end else begin
      if (div_cnt >= clk_div_in) begin
        div_cnt <= {CLKDIV_W{1'b0}};
      end else begin
        div_cnt <= div_cnt + {{(CLKDIV_W-1){1'b0}}, 1'b1};
      end
      clk_div <= (div_cnt < clk_high_in); // RL10
    end
  end

  // ****************************************
  // Traffic LEDs
  // ****************************************
  wire rx_act;
  wire tx_act;
  wire tw_act;

  traffic_pulse #(.PULSE_CYCLES(LED_PULSE_CYCLES), .CW(20)) rx_traffic_led (
    .ref_clk_in (ref_clk_in),
    .rst_b_in   (core_rst_b),
    .event_in   (uart_rx_event_in), // RL7
    .active_out (rx_act)
  );
  traffic_pulse #(.PULSE_CYCLES(LED_PULSE_CYCLES), .CW(20)) tx_traffic_led (
    .ref_clk_in (ref_clk_in),
    .rst_b_in   (core_rst_b),
    .event_in   (uart_tx_event_in), // RL8
    .active_out (tx_act)
  );
  traffic_pulse #(.PULSE_CYCLES(LED_PULSE_CYCLES), .CW(20)) twowire_traffic_led (
    .ref_clk_in (ref_clk_in),
    .rst_b_in   (core_rst_b),
    .event_in   (twowire_event_in), // RL9
    .active_out (tw_act)
  );

  // ****************************************
  // Pin function selection
  // ****************************************
  // Polarity bit 0 means active low, the shipped default, except the configured pin, which is active high at 0
  wire suspend_indicator        = usb_suspend_in ? suspend_indicator_pol : ~suspend_indicator_pol; // RL4
  wire usb_configured_indicator = (usb_configured_in && !usb_suspend_in) ^ cfg_pol; // RL5 RL6
  wire rx_led = rx_act ? led_pol : ~led_pol;
  wire tx_led = tx_act ? led_pol : ~led_pol;
  wire tw_led = tw_act ? led_pol : ~led_pol;

  reg [3:0] next_out;
  reg [3:0] next_oe;
  reg [2:0] next_adc;
  reg [1:0] next_dac;
  reg [2:0] des;
  reg       gpio_oe;
  integer   p;

  always @* begin
    next_out = 4'h0;
    next_oe  = 4'h0;
    next_adc = 3'h0;
    next_dac = 2'h0;
    des      = 3'h0;
    gpio_oe  = 1'b0;
    for (p = 0; p < 4; p = p + 1) begin
      des     = work[p][`SET_DES_MSB:`SET_DES_LSB];
      gpio_oe = ~work[p][`SET_DIR_BIT];
      if (!loaded) begin
        des = 3'h7;
      end
      case (des)
        `DES_GPIO: begin
          next_out[p] = gp_val[p]; // RL1 RL3
          next_oe[p]  = gpio_oe;
        end
        `DES_PRIMARY: begin
          next_oe[p] = 1'b1; // RL1
          case (p)
            0: next_out[p] = suspend_indicator;
            1: next_out[p] = clk_div;
            2: next_out[p] = usb_configured_indicator;
            default: next_out[p] = tw_led;
          endcase
        end
        `DES_ALT_A: begin
          if (p == 0) begin
            next_out[p] = rx_led; // RL2
            next_oe[p]  = 1'b1;
          end else begin
            next_adc[p-1] = 1'b1; // RL12
          end
        end
        `DES_ALT_B: begin
          if (p == 1) begin
            next_out[p] = tx_led; // RL2
            next_oe[p]  = 1'b1;
          end else if (p >= 2) begin
            next_dac[p-2] = 1'b1; // RL13
          end
        end
        default: begin
          next_oe[p] = 1'b0; // RL20
        end
      endcase
    end
  end

  always @(posedge ref_clk_in or negedge core_rst_b) begin
    if (!core_rst_b) begin
      pin_out                    <= 4'h0;
      pin_oe_out                 <= 4'h0;
      adc_channel_en_out         <= 3'h0;
      dac_pin_en_out             <= 2'h0;
      adc_reference_selector_out <= 2'h0;
      dac_reference_selector_out <= 2'h0;
    end else begin
      pin_out                    <= next_out;
      pin_oe_out                 <= next_oe;
      adc_channel_en_out         <= next_adc;
      dac_pin_en_out             <= next_dac;
      adc_reference_selector_out <= chip[`CHIP_ADC_REF_LSB +: 2]; // RL14
      dac_reference_selector_out <= chip[`CHIP_DAC_REF_LSB +: 2]; // RL14
    end
  end

endmodule
`default_nettype wire

// file: tb/gp_pin_partner.sv
// Application circuitry model on the four general-purpose pins
`default_nettype none
module gp_pin_partner (
  // Device side
  input  wire logic [3:0] pin_out_in,
  input  wire logic [3:0] pin_oe_in,
  // Board drive
  input  wire logic [3:0] ext_level_in,
  output logic      [3:0] pin_level_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // Board yields wherever the device drives
  assign pin_level_out = (pin_oe_in & pin_out_in) | (~pin_oe_in & ext_level_in);
endmodule
`default_nettype wire

// file: tb/gp_pin_mux_props.sv
// Concurrent checks on the pin multiplexer ports
`default_nettype none
module gp_pin_mux_props (
  // Clock and resets
  input wire logic        ref_clk_in,
  input wire logic        rst_b_in,
  input wire logic        por_pulse_in,
  // Settings
  input wire logic [39:0] nv_settings_in,
  input wire logic        set_wr_in,
  input wire logic        set_nv_in,
  input wire logic [2:0]  set_addr_in,
  input wire logic [7:0]  set_data_in,
  input wire logic [7:0]  set_rdata_out,
  input wire logic [39:0] nv_settings_out,
  input wire logic        settings_ready_out,
  // Pins and routing
  input wire logic [3:0]  pin_in,
  input wire logic [3:0]  gpio_level_out,
  input wire logic [2:0]  adc_channel_en_out,
  input wire logic [1:0]  dac_pin_en_out,
  input wire logic [3:0]  pin_oe_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in || por_pulse_in);
  // ********
  // Settings store
  // ********
  sequence s_nv_wr;
    settings_ready_out && set_wr_in && set_nv_in && set_addr_in <= 3'h4;
  endsequence
  property p_nv_write;
    s_nv_wr |=> nv_settings_out[8*$past(set_addr_in) +: 8] == $past(set_data_in);
  endproperty
  a_nv_write: assert property (p_nv_write) else $error("stored byte not written");
  property p_nv_hold;
    settings_ready_out && !(set_wr_in && set_nv_in && set_addr_in <= 3'h4) |=> $stable(nv_settings_out);
  endproperty
  a_nv_hold: assert property (p_nv_hold) else $error("stored copy changed");
  property p_load;
    $rose(settings_ready_out) |-> nv_settings_out == $past(nv_settings_in);
  endproperty
  a_load: assert property (p_load) else $error("stored image not loaded");
  property p_ready_hold;
    settings_ready_out |=> settings_ready_out;
  endproperty
  a_ready_hold: assert property (p_ready_hold) else $error("ready dropped");
  property p_not_ready_hiz;
    !settings_ready_out |-> pin_oe_out == 4'h0;
  endproperty
  a_not_ready_hiz: assert property (p_not_ready_hiz) else $error("pin driven before load");
  property p_rdata_oob;
    settings_ready_out && set_addr_in > 3'h4 |=> set_rdata_out == 8'h00;
  endproperty
  a_rdata_oob: assert property (p_rdata_oob) else $error("unmapped byte read nonzero");
  // ********
  // Pins
  // ********
  property p_gpio_level;
    settings_ready_out && $past(settings_ready_out) && $past(settings_ready_out, 2) && $past(settings_ready_out, 3)
      |-> gpio_level_out == $past(pin_in, 3);
  endproperty
  a_gpio_level: assert property (p_gpio_level) else $error("pin level not returned");
  property p_adc_hiz;
    (adc_channel_en_out & pin_oe_out[3:1]) == 3'h0;
  endproperty
  a_adc_hiz: assert property (p_adc_hiz) else $error("analog input pin driven");
  property p_dac_hiz;
    (dac_pin_en_out & pin_oe_out[3:2]) == 2'h0;
  endproperty
  a_dac_hiz: assert property (p_dac_hiz) else $error("analog output pin driven digitally");
endmodule
bind gp_pin_function_mux gp_pin_mux_props i_props (.ref_clk_in, .rst_b_in, .por_pulse_in, .nv_settings_in,
  .set_wr_in, .set_nv_in, .set_addr_in, .set_data_in, .set_rdata_out, .nv_settings_out, .settings_ready_out,
  .pin_in, .gpio_level_out, .adc_channel_en_out, .dac_pin_en_out, .pin_oe_out);
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the general-purpose pin multiplexer
`default_nettype none
`include "gp_pin_mux_consts.vh"
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [39:0] NV_IMAGE = 40'h0b_00_01_04_10;
  logic        ref_clk_in = 1'b0, rst_b_in = 1'b0, por_pulse_in = 1'b0, set_wr_in = 1'b0, set_nv_in = 1'b0;
  logic        edge_clear_in = 1'b0, usb_suspend_in = 1'b0, usb_configured_in = 1'b1;
  logic        uart_rx_event_in = 1'b0, uart_tx_event_in = 1'b0, twowire_event_in = 1'b0;
  logic [39:0] nv_settings_in = NV_IMAGE, nv_settings_out;
  logic [7:0]  set_data_in = 8'h00, set_rdata_out, clk_div_in = 8'h03, clk_high_in = 8'h01;
  logic [3:0]  gpio_set_val_in = 4'h0, gpio_set_wr_in = 4'h0, ext_level = 4'h0;
  logic [3:0]  gpio_level_out, pin_in, pin_out, pin_oe_out;
  logic [2:0]  set_addr_in = 3'h0, adc_channel_en_out;
  logic [1:0]  edge_mode_in = 2'h0, adc_ref, dac_ref, dac_pin_en_out;
  logic        settings_ready_out, edge_flag_out;
  int          err_count = 0, total_checks = 0;
  // Row: pin, setting byte, spare, expected enable, expected level, level checked
  logic [15:0] rows [18] = '{16'h0_08_0, 16'h0_01_7, 16'h0_02_7, 16'h0_03_0, 16'h0_04_0, 16'h0_07_0,
                             16'h1_02_0, 16'h1_03_7, 16'h1_04_0, 16'h1_05_0, 16'h2_01_7, 16'h2_02_0,
                             16'h2_03_0, 16'h2_04_0, 16'h3_01_7, 16'h3_02_0, 16'h3_03_0, 16'h3_06_0};
  always #5 ref_clk_in = ~ref_clk_in;
  gp_pin_function_mux #(.LED_PULSE_CYCLES(20), .RST_FILTER(10), .CLKDIV_W(8)) i_dut (.ref_clk_in, .rst_b_in,
    .por_pulse_in, .nv_settings_in, .set_wr_in, .set_nv_in, .set_addr_in, .set_data_in, .set_rdata_out,
    .nv_settings_out, .settings_ready_out, .gpio_set_val_in, .gpio_set_wr_in, .gpio_level_out, .clk_div_in,
    .clk_high_in, .edge_mode_in, .edge_clear_in, .edge_flag_out, .usb_suspend_in, .usb_configured_in,
    .uart_rx_event_in, .uart_tx_event_in, .twowire_event_in, .adc_channel_en_out, .dac_pin_en_out,
    .adc_reference_selector_out(adc_ref), .dac_reference_selector_out(dac_ref), .pin_in, .pin_out, .pin_oe_out);
  gp_pin_partner i_partner (.pin_out_in(pin_out), .pin_oe_in(pin_oe_out), .ext_level_in(ext_level),
    .pin_level_out(pin_in));
  // ********
  // Tasks, all entered and left at a falling edge
  // ********
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask
  task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic nv, input logic [2:0] a, input logic [7:0] d);
    set_nv_in = nv;
    set_addr_in = a;
    set_data_in = d;
    set_wr_in = 1'b1;
    tick(1);
    set_wr_in = 1'b0;
    tick(2);
  endtask
  task automatic rd(input logic nv, input logic [2:0] a, input logic [7:0] exp);
    set_nv_in = nv;
    set_addr_in = a;
    tick(1);
    chk("set_rdata_out", exp, set_rdata_out);
  endtask
  task automatic ev(input int k);
    {twowire_event_in, uart_tx_event_in, uart_rx_event_in} = 3'h1 << k;
    tick(1);
    {twowire_event_in, uart_tx_event_in, uart_rx_event_in} = 3'h0;
  endtask
  task automatic clr;
    edge_clear_in = 1'b1;
    tick(1);
    edge_clear_in = 1'b0;
    tick(2);
  endtask
  task automatic wait_ready;
    int i;
    for (i = 0; i < 60 && settings_ready_out !== 1'b1; i++) tick(1);
    if (settings_ready_out !== 1'b1) begin
      err_count++;
      $display("mismatch settings_ready_out exp 1 got %b", settings_ready_out);
      give_verdict();
    end else tick(1);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    logic [39:0] hi;
    tick(2);
    chk("pin_oe_out", 4'h0, pin_oe_out);
    rst_b_in = 1'b1;
    wait_ready();
    chk("nv_settings_out", NV_IMAGE, nv_settings_out);
    chk("pin_oe_out", 4'hd, pin_oe_out);
    chk("pin_out", 4'h5, pin_out);
    chk("adc_ref", 2'h2, adc_ref);
    chk("dac_ref", 2'h3, dac_ref);
    for (int r = 0; r < 18; r++) begin
      wr(1'b0, rows[r][14:12], rows[r][11:4]);
      chk("row pin_oe_out", rows[r][2], pin_oe_out[rows[r][13:12]]);
      if (rows[r][0]) chk("row pin_out", rows[r][1], pin_out[rows[r][13:12]]);
    end
    for (int p = 1; p < 4; p++) wr(1'b0, p[2:0], 8'h02);
    chk("adc_channel_en_out", 3'h7, adc_channel_en_out);
    wr(1'b0, 3'h2, 8'h03);
    wr(1'b0, 3'h3, 8'h03);
    chk("dac_pin_en_out", 2'h3, dac_pin_en_out);
    wr(1'b0, 3'h4, 8'h06);
    chk("adc_ref", 2'h1, adc_ref);
    chk("dac_ref", 2'h2, dac_ref);
    rd(1'b0, 3'h4, 8'h06);
    rd(1'b1, 3'h4, 8'h0b);
    rd(1'b0, 3'h5, 8'h00);
    wr(1'b1, 3'h0, 8'h02);
    chk("nv byte0", 8'h02, nv_settings_out[7:0]);
    rd(1'b0, 3'h0, 8'h07);
    wr(1'b0, 3'h0, 8'h00);
    wr(1'b0, 3'h3, 8'h08);
    for (int v = 0; v < 2; v++) begin
      gpio_set_val_in = {3'h0, v[0]};
      gpio_set_wr_in = 4'h1;
      ext_level[3] = v[0];
      tick(1);
      gpio_set_wr_in = 4'h0;
      tick(3);
      chk("pin_out0", v[0], pin_out[0]);
      chk("gpio_level_out3", v[0], gpio_level_out[3]);
    end
    wr(1'b0, 3'h1, 8'h04);
    edge_mode_in = `EDGE_RISE;
    clr();
    chk("edge_flag_out", 1'b0, edge_flag_out);
    ext_level[1] = 1'b1;
    tick(6);
    chk("edge_flag_out", 1'b1, edge_flag_out);
    clr();
    ext_level[1] = 1'b0;
    tick(6);
    chk("edge_flag_out", 1'b0, edge_flag_out);
    edge_mode_in = `EDGE_FALL;
    ext_level[1] = 1'b1;
    tick(6);
    chk("edge_flag_out", 1'b0, edge_flag_out);
    ext_level[1] = 1'b0;
    tick(6);
    chk("edge_flag_out", 1'b1, edge_flag_out);
    edge_mode_in = `EDGE_BOTH;
    clr();
    ext_level[1] = 1'b1;
    tick(6);
    chk("edge_flag_out both rise", 1'b1, edge_flag_out);
    clr();
    ext_level[1] = 1'b0;
    tick(6);
    chk("edge_flag_out both fall", 1'b1, edge_flag_out);
    edge_mode_in = `EDGE_NONE;
    clr();
    ext_level[1] = 1'b1;
    tick(6);
    chk("edge_flag_out none", 1'b0, edge_flag_out);
    wr(1'b0, 3'h0, 8'h01);
    wr(1'b0, 3'h2, 8'h01);
    usb_suspend_in = 1'b1;
    tick(3);
    chk("pin_out", 4'h0, pin_out & 4'h5);
    usb_suspend_in = 1'b0;
    tick(3);
    chk("pin_out", 4'h5, pin_out & 4'h5);
    usb_configured_in = 1'b0;
    tick(3);
    chk("pin_out2", 1'b0, pin_out[2]);
    usb_configured_in = 1'b1;
    wr(1'b0, 3'h1, 8'h01);
    hi = 40'h0;
    repeat (40) begin
      tick(1);
      hi = hi + pin_out[1];
    end
    chk("clock high cycles", 40'd10, hi);
    // Stored medium now holds the new pin0 byte
    nv_settings_in = {NV_IMAGE[39:8], 8'h02};
    por_pulse_in = 1'b1;
    tick(1);
    por_pulse_in = 1'b0;
    chk("settings_ready_out", 1'b0, settings_ready_out);
    wait_ready();
    chk("pin0 oe and level", 2'h3, {pin_oe_out[0], pin_out[0]});
    ev(0);
    tick(2);
    chk("rx led", 1'b0, pin_out[0]);
    tick(8);
    ev(0);
    tick(15);
    chk("rx led retrigger", 1'b0, pin_out[0]);
    tick(10);
    chk("rx led end", 1'b1, pin_out[0]);
    wr(1'b0, 3'h1, 8'h03);
    wr(1'b0, 3'h3, 8'h01);
    ev(1);
    tick(2);
    chk("tx led", 1'b0, pin_out[1]);
    ev(2);
    tick(2);
    chk("twowire led", 1'b0, pin_out[3]);
    rst_b_in = 1'b0;
    tick(1);
    chk("settings_ready_out", 1'b0, settings_ready_out);
    rst_b_in = 1'b1;
    tick(8);
    chk("settings_ready_out", 1'b0, settings_ready_out);
    wait_ready();
    give_verdict();
  end
endmodule
`default_nettype wire
